// ---- rtl/fkm_seq.sv ----
`timescale 1ns/1ps
// Operation
// - backdoor verify first checks key enable; disabled gives access error
// - key enable other than binary 10 means disabled
// - key word zero compares with first stored key word, rest in order
// - all keys equal releases the secured state
// - mismatch keeps security and locks out backdoor until reset
// - completion flag sets after backdoor verify whatever the outcome
// - backdoor verify with index not 100 gives access error
// - user margin command stores level for block then sets completion
// - data-block level affects data reads; program-block level affects program reads, and data reads while data levels are 0
// - user settings 0, 1, 2 are accepted
// - user margin error on bad index, block or setting
// - field margin command only honoured in special modes
// - field margin also accepts settings 3 and 4
// - field margin command stores level for block then sets completion
// - field level on program block governs program reads, and data reads while no data level is set; data only data
// - field margin error on bad index, mode, block or setting
module fkm_seq
   import fkm_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [1:0]  key_enable_field,
   input  wire logic        special_mode,
   input  wire logic        secured_at_reset,
   input  wire logic [15:0] stored_key0,
   input  wire logic [15:0] stored_key1,
   input  wire logic [15:0] stored_key2,
   input  wire logic [15:0] stored_key3,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             secured,
   output logic [2:0]       data_read_margin,
   output logic [2:0]       prog_read_margin
);
   import fkm_pkg::*;

   typedef enum logic [1:0] {FKM_IDLE, FKM_CHECK, FKM_KEYS} fkm_state_t;

   fkm_state_t  state;
   logic [15:0] command_object_words [6];
   logic [2:0]  command_word_index;
   logic        command_complete_flag;
   logic        access_error_flag;
   logic        lockout;
   logic [2:0]  user_data_marg;
   logic [2:0]  user_prog_marg;
   logic [2:0]  field_data_marg;
   logic [2:0]  field_prog_marg;
   logic [1:0]  key_en_s1;
   logic [1:0]  key_en_s2;
   logic        spec_s1;
   logic        spec_s2;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   //////////////////////////////////////////////////////////////////////
   // pins from outside the domain pass two flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_en_s1 <= 2'h0;
         key_en_s2 <= 2'h0;
         spec_s1   <= 1'b0;
         spec_s2   <= 1'b0;
      end else if (ce) begin
         key_en_s1 <= key_enable_field;
         key_en_s2 <= key_en_s1;
         spec_s1   <= special_mode;
         spec_s2   <= spec_s1;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // axi write path: address and data taken in either order
   wire wr_fire   = aw_held && w_held && !s_axi_bvalid;
   wire rd_fire   = s_axi_arvalid && s_axi_arready;
   wire hit_ctrl  = (aw_addr == OFF_CTRL);
   wire hit_stat  = (aw_addr == OFF_STATUS);
   wire hit_word  = (aw_addr == OFF_WORD);
   wire wr_mapped = hit_ctrl || hit_stat || hit_word;
   // launch: writing one to the completion flag clears it and starts
   wire launch    = wr_fire && hit_stat && w_strb[0] && w_data[ST_COMPLETE]
                    && command_complete_flag;
   wire clr_err   = wr_fire && hit_stat && w_strb[0] && w_data[ST_ACC_ERR];
   // command words only writable while idle, else they would shift mid-run
   wire word_we   = wr_fire && hit_word && command_complete_flag;
   wire idx_we    = wr_fire && hit_ctrl && w_strb[0] && command_complete_flag;

   // readies drop while frozen so no beat is lost to a stalled flop
   assign s_axi_awready = ce && !aw_held;
   assign s_axi_wready  = ce && !w_held;
   assign s_axi_arready = ce && !s_axi_rvalid;

   // each half waits until both are in; a new response waits for the old one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= FKM_AXI_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? FKM_AXI_RESP_OKAY : FKM_AXI_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // command word storage, written at the current index
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         command_word_index <= 3'h0;
         for (int i = 0; i < 6; i++) command_object_words[i] <= 16'h0000;
      end else if (ce) begin
         if (idx_we) command_word_index <= w_data[2:0];
         if (word_we && command_word_index < 3'h6) begin
            if (w_strb[0]) command_object_words[command_word_index][7:0]  <= w_data[7:0];
            if (w_strb[1]) command_object_words[command_word_index][15:8] <= w_data[15:8];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // decode of the launched command
   wire [7:0]  cmd_code  = command_object_words[0][15:8];
   wire [1:0]  cmd_blk   = command_object_words[0][1:0];
   wire [15:0] marg_set  = command_object_words[1];
   wire        is_bd     = (cmd_code == CMD_BACKDOOR);
   wire        is_um     = (cmd_code == CMD_USER_MARG);
   wire        is_fm     = (cmd_code == CMD_FIELD_MARG);
   wire        blk_ok    = (cmd_blk == BLK_PROG) || (cmd_blk == BLK_DATA);
   wire        um_set_ok = (marg_set <= MARG_USER0);
   wire        fm_set_ok = (marg_set <= MARG_FIELD0);
   // backdoor: index, key enable and lockout all abort before compare
   wire        bd_err    = (command_word_index != IDX_BACKDOOR)
                           || (key_en_s2 != KEY_ENABLED)
                           || lockout;
   wire        um_err    = (command_word_index != IDX_MARGIN) || !blk_ok
                           || !um_set_ok;
   wire        fm_err    = (command_word_index != IDX_MARGIN) || !spec_s2
                           || !blk_ok || !fm_set_ok;

   // unknown codes are refused like a bad parameter
   wire        cmd_bad   = !(is_bd || is_um || is_fm);
   wire        cmd_err   = (is_bd && bd_err) || (is_um && um_err) || (is_fm && fm_err)
                           || cmd_bad;

   // supplied keys sit at command words one to four
   logic [15:0] sup_keys [N_KEYS];
   logic [15:0] ref_keys [N_KEYS];
   logic        cmp_done;
   logic        cmp_match;
   genvar k;
   for (k = 0; k < N_KEYS; k++) begin : g_keys
      assign sup_keys[k] = command_object_words[k + 1];
   end
   // stored key words in address order, word zero first
   assign ref_keys[0] = stored_key0;
   assign ref_keys[1] = stored_key1;
   assign ref_keys[2] = stored_key2;
   assign ref_keys[3] = stored_key3;
   // compare starts only once every refusal check has passed
   wire        cmp_start = (state == FKM_CHECK) && is_bd && !bd_err;
   // a good compare is the only way out of the secured state
   wire        key_ok    = (state == FKM_KEYS) && cmp_done && cmp_match;

   // the compare walks one word per cycle
   fkm_key_cmp #(.N(N_KEYS)) u_cmp (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .start    (cmp_start),
      .supplied (sup_keys),
      .stored   (ref_keys),
      .done     (cmp_done),
      .match    (cmp_match)
   );

   //////////////////////////////////////////////////////////////////////
   // sequencer; errors leave levels and security untouched
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state                 <= FKM_IDLE;
         command_complete_flag <= 1'b1;
         access_error_flag     <= 1'b0;
         lockout               <= 1'b0;
         user_data_marg        <= MARG_RST;
         user_prog_marg        <= MARG_RST;
         field_data_marg       <= MARG_RST;
         field_prog_marg       <= MARG_RST;
      end else if (ce) begin
         if (clr_err) access_error_flag <= 1'b0;
         unique case (state)
            FKM_IDLE: begin
               if (launch) begin
                  command_complete_flag <= 1'b0;
                  state                 <= FKM_CHECK;
               end
            end
            FKM_CHECK: begin
               if (is_bd && !bd_err) begin
                  state <= FKM_KEYS;
               end else begin
                  state                 <= FKM_IDLE;
                  command_complete_flag <= 1'b1;
                  if (cmd_err) begin
                     access_error_flag <= 1'b1;
                  end else if (is_um) begin
                     if (cmd_blk == BLK_PROG) user_prog_marg <= marg_set[2:0];
                     else                     user_data_marg <= marg_set[2:0];
                  end else if (is_fm) begin
                     if (cmd_blk == BLK_PROG) field_prog_marg <= marg_set[2:0];
                     else                     field_data_marg <= marg_set[2:0];
                  end
               end
            end
            FKM_KEYS: begin
               if (cmp_done) begin
                  state                 <= FKM_IDLE;
                  command_complete_flag <= 1'b1;
                  // lockout and error rise together on a mismatch
                  if (!cmp_match) begin
                     lockout           <= 1'b1;
                     access_error_flag <= 1'b1;
                  end
               end
            end
            default: state <= FKM_IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // security: loaded after reset, released only by a good key
   logic sec_loaded;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         secured    <= 1'b1;
         sec_loaded <= 1'b0;
      end else if (ce) begin
         if (!sec_loaded) begin
            sec_loaded <= 1'b1;
            secured    <= secured_at_reset;
         end else if (key_ok) begin
            secured <= 1'b0;
         end
      end
   end

   // field level wins over user level once set; program level covers data reads too while the data level is zero
   wire [2:0] prog_lvl = (field_prog_marg != MARG_RST) ? field_prog_marg : user_prog_marg;
   wire [2:0] data_lvl = (field_data_marg != MARG_RST) ? field_data_marg : user_data_marg;
   // registered so the array reads see a settled level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prog_read_margin <= MARG_RST;
         data_read_margin <= MARG_RST;
      end else if (ce) begin
         prog_read_margin <= prog_lvl;
         data_read_margin <= (data_lvl != MARG_RST) ? data_lvl : prog_lvl;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // read path: one named select per register word
   wire [5:0]  rd_adr   = s_axi_araddr[7:2];
   wire        rd_ctrl  = (rd_adr == OFF_CTRL[7:2]);
   wire        rd_stat  = (rd_adr == OFF_STATUS[7:2]);
   wire        rd_word  = (rd_adr == OFF_WORD[7:2]);
   wire        rd_marg  = (rd_adr == OFF_MARGIN[7:2]);
   wire        rd_key   = (rd_adr == OFF_KEY[7:2]);
   // an index past the last word reads zero instead of wrapping
   wire [15:0] cur_word = (command_word_index < 3'h6) ? command_object_words[command_word_index]
                                                      : 16'h0000;
   wire [31:0] rd_mux   =
      rd_ctrl ? {29'h0, command_word_index} :
      rd_stat ? {24'h0, command_complete_flag, 1'b0, access_error_flag, 5'h0} :
      rd_word ? {16'h0, cur_word} :
      rd_marg ? {20'h0, field_prog_marg, field_data_marg, user_prog_marg, user_data_marg} :
      rd_key  ? {30'h0, lockout, secured} : 32'h0;
   wire        rd_mapped = rd_ctrl || rd_stat || rd_word || rd_marg || rd_key;

   // the answer stands until rready; arready stays low meanwhile
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= FKM_AXI_RESP_OKAY;
      end else if (ce) begin
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_mapped ? FKM_AXI_RESP_OKAY : FKM_AXI_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ---- rtl/fkm_pkg.sv ----
package fkm_pkg;

   // command codes
   localparam logic [7:0] CMD_BACKDOOR   = 8'h0c;
   localparam logic [7:0] CMD_USER_MARG  = 8'h0d;
   localparam logic [7:0] CMD_FIELD_MARG = 8'h0e;

   // index expected at launch
   localparam logic [2:0] IDX_BACKDOOR = 3'h4;
   localparam logic [2:0] IDX_MARGIN   = 3'h1;

   // key enable value that permits backdoor access
   localparam logic [1:0] KEY_ENABLED = 2'h2;

   // global address [17:16] of each block
   localparam logic [1:0] BLK_PROG = 2'h3;
   localparam logic [1:0] BLK_DATA = 2'h0;

   // margin settings
   localparam logic [15:0] MARG_NORMAL  = 16'h0000;
   localparam logic [15:0] MARG_USER1   = 16'h0001;
   localparam logic [15:0] MARG_USER0   = 16'h0002;
   localparam logic [15:0] MARG_FIELD1  = 16'h0003;
   localparam logic [15:0] MARG_FIELD0  = 16'h0004;
   localparam logic [2:0]  MARG_RST     = 3'h0;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_WORD   = 8'h08;
   localparam logic [7:0] OFF_MARGIN = 8'h0c;
   localparam logic [7:0] OFF_KEY    = 8'h10;

   // status bit positions
   localparam int ST_COMPLETE = 7;
   localparam int ST_ACC_ERR  = 5;

   // key compare takes one cycle per word
   localparam int N_KEYS = 4;

   typedef enum logic [1:0] {FKM_AXI_RESP_OKAY = 2'h0, FKM_AXI_RESP_SLVERR = 2'h2} fkm_resp_t;

endpackage

// ---- rtl/fkm_key_cmp.sv ----
`timescale 1ns/1ps
// compares supplied key words against stored words one per cycle
module fkm_key_cmp #(
   parameter int N = 4
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic        start,
   input  wire logic [15:0] supplied [N],
   input  wire logic [15:0] stored   [N],
   output logic             done,
   output logic             match
);
   logic [$clog2(N+1)-1:0] cnt;
   logic                   busy;
   logic                   all_eq;
   logic [N-1:0]           eq;

   // per-word equality, word zero against first stored word
   genvar g;
   for (g = 0; g < N; g++) begin : g_eq
      assign eq[g] = (supplied[g] == stored[g]);
   end
   assign all_eq = &eq;

   //////////////////////////////////////////////////////////////////////
   // walk the words so timing resembles a real sequenced read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt   <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
         match <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            cnt  <= '0;
         end else if (busy) begin
            if (cnt == ($clog2(N+1))'(N - 1)) begin
               busy  <= 1'b0;
               done  <= 1'b1;
               match <= all_eq;
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   end
endmodule

// ---- verif/fkm_seq_sva.sv ----
`timescale 1ns/1ps
// port-level checks of the command sequencer
module fkm_seq_sva
   import fkm_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        secured,
   input wire logic [2:0]  data_read_margin,
   input wire logic [2:0]  prog_read_margin
);
   logic [3:0] since_b;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////
   // age of the last write response; state moves only just after a launch
   always_ff @(posedge aclk) begin
      if (!aresetn || s_axi_bvalid) begin
         since_b <= 4'h0;
      end else if (since_b != 4'hf) begin
         since_b <= since_b + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // answers stand until taken
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_follow;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_follow: assert property (p_r_follow) else $error("read answer late");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("address taken while busy");
   property p_rd_err;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h04 |=>
         s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
   property p_resp_ok;
      s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2};
   endproperty
   a_resp_ok: assert property (p_resp_ok) else $error("illegal write response");
   property p_sec_sticky;
      !secured |=> !secured;
   endproperty
   a_sec_sticky: assert property (p_sec_sticky) else $error("secured rose");
   property p_sec_cause;
      $fell(secured) |-> since_b < 4'ha || s_axi_bvalid;
   endproperty
   a_sec_cause: assert property (p_sec_cause) else $error("unlock uncaused");
   property p_marg_cause;
      $changed(data_read_margin) || $changed(prog_read_margin) |->
         since_b < 4'h4 || s_axi_bvalid;
   endproperty
   a_marg_cause: assert property (p_marg_cause) else $error("margin moved");
   property p_marg_range;
      data_read_margin <= 3'h4 && prog_read_margin <= 3'h4;
   endproperty
   a_marg_range: assert property (p_marg_range) else $error("bad margin");

   // main scenarios
   c_unlock: cover property ($fell(secured));
   c_marg: cover property ($changed(prog_read_margin));
   c_rd_err: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h04);
endmodule

bind fkm_seq fkm_seq_sva fkm_seq_sva_inst (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .secured, .data_read_margin,
   .prog_read_margin);

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
   import fkm_pkg::*;
   logic        aclk, aresetn, ce, special_mode, secured_at_reset, secured;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  key_enable_field, s_axi_bresp, s_axi_rresp, rs;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv, st, r;
   logic [3:0]  s_axi_wstrb;
   logic [2:0]  data_read_margin, prog_read_margin, ud, up, fd, fp;
   logic [15:0] sk [4];
   logic [15:0] bad [4];
   int          failures, compares, seed, n, m, j;

   fkm_seq fkm_seq_inst (.aclk, .aresetn, .ce, .key_enable_field, .special_mode,
      .secured_at_reset, .stored_key0(sk[0]), .stored_key1(sk[1]), .stored_key2(sk[2]),
      .stored_key3(sk[3]), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .secured, .data_read_margin,
      .prog_read_margin);

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task tmo;
      failures++;
      print_verdict();
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // k: 0 write response, 1 read data, 2 read address
   task wt(input int k);
      for (n = 0; n < 60; n++) begin
         @(posedge aclk);
         if (k == 0 && s_axi_bvalid && s_axi_bready) break;
         if (k == 1 && s_axi_rvalid && s_axi_rready) break;
         if (k == 2 && s_axi_arvalid && s_axi_arready) break;
      end
      if (n == 60) tmo();
   endtask
   // ready raised late so the slave must hold its answer
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ad;
      logic wd;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      for (n = 0; n < 60 && !(ad && wd); n++) begin
         @(posedge aclk);
         if (!ad && s_axi_awready) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wd && s_axi_wready) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      if (!(ad && wd)) tmo();
      repeat (2) @(posedge aclk);
      s_axi_bready <= 1'b1;
      wt(0);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      wt(2);
      s_axi_arvalid <= 1'b0;
      repeat (2) @(posedge aclk);
      s_axi_rready <= 1'b1;
      wt(1);
      rdv = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task rst;
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      {ud, up, fd, fp} = 12'h0;
      @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task ld(input logic [2:0] i, input logic [15:0] w);
      wr(OFF_CTRL, {29'h0, i});
      wr(OFF_WORD, {16'h0, w});
   endtask
   // launch, wait for completion, then clear the error flag
   task run(input logic [2:0] i);
      wr(OFF_CTRL, {29'h0, i});
      wr(OFF_STATUS, 32'h80);
      for (m = 0; m < 20; m++) begin
         rd(OFF_STATUS);
         if (rdv[ST_COMPLETE] === 1'b1) break;
      end
      if (m == 20) tmo();
      st = rdv;
      wr(OFF_STATUS, 32'h20);
   endtask
   task bd(input logic [15:0] k [4], input logic [2:0] i, input logic e, input logic s);
      ld(3'h0, {CMD_BACKDOOR, 8'h00}); // issued by the bench, not key-block code
      for (j = 0; j < 4; j++) ld(3'(j + 1), k[j]);
      run(i);
      chk("bd_err", st[ST_ACC_ERR], e);
      chk("bd_done", st[ST_COMPLETE], 1'b1);
      chk("secured", secured, s);
   endtask
   function logic mg_err(logic [7:0] c, logic [1:0] b, logic [15:0] v, logic [2:0] i);
      return i != IDX_MARGIN || (c == CMD_FIELD_MARG && !special_mode) ||
         (b != BLK_PROG && b != BLK_DATA) || v > (c == CMD_FIELD_MARG ? 16'h4 : 16'h2);
   endfunction
   task mg(input logic [7:0] c, input logic [1:0] b, input logic [15:0] v, input logic [2:0] i);
      logic e;
      ld(3'h0, {c, 6'h0, b});
      ld(3'h1, v);
      e = mg_err(c, b, v, i);
      run(i);
      if (!e && c == CMD_FIELD_MARG && b == BLK_PROG) fp = v[2:0];
      else if (!e && c == CMD_FIELD_MARG) fd = v[2:0];
      else if (!e && b == BLK_PROG) up = v[2:0];
      else if (!e) ud = v[2:0];
      chk("mg_err", st[ST_ACC_ERR], e);
      chk("mg_done", st[ST_COMPLETE], 1'b1);
      rd(OFF_MARGIN);
      chk("margins", rdv, {20'h0, fp, fd, up, ud});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h58cc;
      {failures, compares} = 0;
      for (j = 0; j < 4; j++) sk[j] = 16'($random(seed));
      sk[1] = ~sk[0];
      bad = '{sk[1], sk[0], sk[2], sk[3]};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
      s_axi_wstrb <= 4'hf;
      ce <= 1'b1;
      special_mode <= 1'b0;
      secured_at_reset <= 1'b1;
      key_enable_field <= KEY_ENABLED;
      rst();
      rd(OFF_STATUS);
      chk("status_rst", rdv & 32'ha0, 32'h80);
      rd(OFF_MARGIN);
      chk("margin_rst", rdv, 32'h0);
      rd(OFF_KEY);
      chk("keystat_rst", rdv[1:0], 2'h1);
      rd(8'h14);
      chk("unmapped_rd", rs, FKM_AXI_RESP_SLVERR);
      wr(8'h18, 32'h1);
      chk("unmapped_wr", rs, FKM_AXI_RESP_SLVERR);
      $display("test reset done");
      // every disabled key enable value, then a wrong index
      for (int t = 0; t < 3; t++) begin
         key_enable_field <= 2'(t == 2 ? 3 : t);
         bd(sk, IDX_BACKDOOR, 1'b1, 1'b1);
      end
      key_enable_field <= KEY_ENABLED;
      bd(sk, 3'h3, 1'b1, 1'b1);
      bd(sk, IDX_BACKDOOR, 1'b0, 1'b0);
      rst();
      bd(bad, IDX_BACKDOOR, 1'b1, 1'b1);
      rd(OFF_KEY);
      chk("lockout", rdv[1:0], 2'h3);
      bd(sk, IDX_BACKDOOR, 1'b1, 1'b1);
      rst();
      bd(sk, IDX_BACKDOOR, 1'b0, 1'b0);
      $display("test backdoor done");
      // level routing between the two blocks
      rst();
      mg(CMD_USER_MARG, BLK_PROG, MARG_USER1, IDX_MARGIN);
      chk("rd_margins", {data_read_margin, prog_read_margin}, 6'o11);
      mg(CMD_USER_MARG, BLK_DATA, MARG_USER0, IDX_MARGIN);
      chk("rd_margins", {data_read_margin, prog_read_margin}, 6'o21);
      special_mode <= 1'b1; // special mode stands in for factory verify
      mg(CMD_FIELD_MARG, BLK_DATA, MARG_FIELD0, IDX_MARGIN);
      chk("rd_margins", {data_read_margin, prog_read_margin}, 6'o41);
      mg(CMD_FIELD_MARG, BLK_PROG, MARG_FIELD1, IDX_MARGIN);
      chk("rd_margins", {data_read_margin, prog_read_margin}, 6'o43);
      $display("test margin routing done");
      for (int t = 0; t < 40; t++) begin
         r = $random(seed);
         special_mode <= r[0];
         @(posedge aclk);
         mg(r[1] ? CMD_FIELD_MARG : CMD_USER_MARG, r[3:2], {7'h0, r[7] & r[8], 5'h0, r[6:4]},
            r[9] & r[10] ? r[13:11] : IDX_MARGIN);
      end
      $display("test margin random done");
      print_verdict();
   end
endmodule
